// [logic/pzio_pkg.sv]
// Port zero constants, register map and field layout
`default_nettype none
package pzio_pkg;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h80;
  localparam logic [7:0] ADDR_IRQ_CFG = 8'hE4;
  localparam logic [7:0] ADDR_SKIP = 8'hD4;
  localparam logic [7:0] ADDR_FUNC_A = 8'hE2;
  localparam logic [7:0] ADDR_FUNC_B = 8'hE3;
  localparam logic [7:0] ADDR_IN_MODE = 8'hF1;
  localparam logic [7:0] ADDR_OUT_MODE = 8'hA4;
  localparam logic [7:0] BIT_BASE_PORT = 8'h80;
  localparam logic [7:0] RST_PORT_DATA = 8'hFF;
  localparam logic [7:0] RST_IRQ_CFG = 8'h01;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_FUNC = 8'h00;
  localparam logic [7:0] RST_IN_MODE = 8'hFF;
  localparam logic [7:0] RST_OUT_MODE = 8'h00;
  localparam logic [7:0] RO_MASK_SIX = 8'h41;
  localparam int IRQ0_SEL_LSB = 0;
  localparam int IRQ0_POL_BIT = 3;
  localparam int IRQ1_SEL_LSB = 4;
  localparam int IRQ1_POL_BIT = 7;
  localparam int NUM_PINS = 8;
  localparam int NUM_FUNCS = 8;
  localparam int DEBUG_PIN = 7;
  localparam int FUNC_TW_DATA = 0;
  localparam int FUNC_TW_CLK = 1;
endpackage
`default_nettype wire

// [logic/pzio_sync.sv]
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pzio_sync import pzio_pkg::*; #(
  parameter int WIDTH = 8,
  parameter logic [7:0] INIT = 8'hFF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= INIT[WIDTH-1:0];
      stage2 <= INIT[WIDTH-1:0];
      stage3 <= INIT[WIDTH-1:0];
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level moves only once two later stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= INIT[WIDTH-1:0];
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/pzio_xbar.sv]
// Priority crossbar: enabled functions onto free pins
`default_nettype none
module pzio_xbar import pzio_pkg::*; (
  input wire logic [NUM_PINS-1:0] skip,
  input wire logic [NUM_FUNCS-1:0] func_en,
  output logic [NUM_PINS-1:0] pin_taken,
  output logic [2:0] pin_func [NUM_PINS]
);
  logic [NUM_PINS-1:0] free;
  logic found;

  // Function index is its priority; lowest index first
  always_comb begin
    free = ~skip;
    found = 1'b0;
    pin_taken = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_func[p] = 3'h0;
    end
    for (int f = 0; f < NUM_FUNCS; f++) begin
      found = 1'b0;
      if (func_en[f]) begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (!found && free[p]) begin
            pin_func[p] = 3'(f);
            pin_taken[p] = 1'b1;
            free[p] = 1'b0;
            found = 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/pzio_top.sv]
// Port zero: data latch, crossbar pin drive, external interrupt routing
`default_nettype none
module pzio_top import pzio_pkg::*; #(
  parameter bit SIX_PIN = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_wval,
  input wire logic sfr_bit_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_bit_rdata,
  input wire logic [NUM_FUNCS-1:0] func_out,
  output logic [NUM_FUNCS-1:0] func_in,
  input wire logic debug_data_oe,
  input wire logic debug_data_out,
  output logic debug_data_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pin_analog,
  output logic external_irq_zero,
  output logic external_irq_one,
  output logic irq_zero_event,
  output logic irq_one_event,
  output logic wake_event
);
  logic [7:0] port_data_latch;
  logic [7:0] ext_irq_pin_config;
  logic [7:0] crossbar_skip_bits;
  logic [7:0] crossbar_func_select_a;
  logic [7:0] crossbar_func_select_b;
  logic [7:0] port_input_mode;
  logic [7:0] port_output_mode;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_taken;
  logic [2:0] pin_func [NUM_PINS];
  logic [NUM_FUNCS-1:0] func_en;
  logic [7:0] wr_mask;
  logic [2:0] irq_zero_pin_select;
  logic [2:0] irq_one_pin_select;
  logic irq_zero_polarity;
  logic irq_one_polarity;
  logic next_irq_zero;
  logic next_irq_one;
  logic next_rise_zero;
  logic next_rise_one;
  logic bit_hit;
  logic [2:0] bit_idx;
  logic [7:0] next_rdata;
  logic [NUM_PINS-1:0] next_out;
  logic [NUM_PINS-1:0] next_oe_n;
  logic [NUM_FUNCS-1:0] next_func_in;

  // Bits fixed on the reduced pin variant
  localparam logic [7:0] RO_MASK = SIX_PIN ? RO_MASK_SIX : 8'h00;

  function automatic logic sel_pin(input logic [7:0] lv, input logic [2:0] idx);
    return lv[idx];
  endfunction

  function automatic logic is_hit(input logic [7:0] a, input logic [7:0] base);
    return a == base;
  endfunction

  pzio_sync #(
    .WIDTH(NUM_PINS),
    .INIT(8'hFF)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(pin_in),
    .level(pin_level)
  );

  pzio_xbar u_xbar (
    .skip(crossbar_skip_bits),
    .func_en(func_en),
    .pin_taken(pin_taken),
    .pin_func(pin_func)
  );

  assign func_en = {crossbar_func_select_b[3:0], crossbar_func_select_a[3:0]};
  assign wr_mask = ~RO_MASK;
  assign irq_zero_pin_select = ext_irq_pin_config[IRQ0_SEL_LSB +: 3];
  assign irq_one_pin_select = ext_irq_pin_config[IRQ1_SEL_LSB +: 3];
  assign irq_zero_polarity = ext_irq_pin_config[IRQ0_POL_BIT];
  assign irq_one_polarity = ext_irq_pin_config[IRQ1_POL_BIT];
  assign bit_hit = sfr_bit_addr[7:3] == BIT_BASE_PORT[7:3];
  assign bit_idx = sfr_bit_addr[2:0];

  // Port data latch, byte and bit writes
  always_ff @(posedge clk) begin
    if (srst) begin
      port_data_latch <= RST_PORT_DATA;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_PORT_DATA)) begin
      port_data_latch <= (sfr_wdata & wr_mask) | (port_data_latch & RO_MASK);
    end else if (sfr_bit_wr && bit_hit && !RO_MASK[bit_idx]) begin
      port_data_latch[bit_idx] <= sfr_bit_wval;
    end
  end

  // Interrupt pin configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_irq_pin_config <= RST_IRQ_CFG;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_IRQ_CFG)) begin
      ext_irq_pin_config <= sfr_wdata;
    end
  end

  // Crossbar skip selection
  always_ff @(posedge clk) begin
    if (srst) begin
      crossbar_skip_bits <= RST_SKIP;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_SKIP)) begin
      crossbar_skip_bits <= sfr_wdata;
    end
  end

  // Function enables, low four functions
  always_ff @(posedge clk) begin
    if (srst) begin
      crossbar_func_select_a <= RST_FUNC;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_FUNC_A)) begin
      crossbar_func_select_a <= sfr_wdata;
    end
  end

  // Function enables, high four functions
  always_ff @(posedge clk) begin
    if (srst) begin
      crossbar_func_select_b <= RST_FUNC;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_FUNC_B)) begin
      crossbar_func_select_b <= sfr_wdata;
    end
  end

  // Input mode is never set for the user by the crossbar
  always_ff @(posedge clk) begin
    if (srst) begin
      port_input_mode <= RST_IN_MODE;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_IN_MODE)) begin
      port_input_mode <= sfr_wdata;
    end
  end

  // Output mode; two-wire pins override it at the drive
  always_ff @(posedge clk) begin
    if (srst) begin
      port_output_mode <= RST_OUT_MODE;
    end else if (sfr_wr && is_hit(sfr_addr, ADDR_OUT_MODE)) begin
      port_output_mode <= sfr_wdata;
    end
  end

  // Read mux; analog pins read low since their input buffer is off
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      ADDR_PORT_DATA: begin
        if (sfr_rmw) begin
          next_rdata = port_data_latch;
        end else begin
          next_rdata = pin_level & port_input_mode;
        end
      end
      ADDR_IRQ_CFG: next_rdata = ext_irq_pin_config;
      ADDR_SKIP: next_rdata = crossbar_skip_bits;
      ADDR_FUNC_A: next_rdata = crossbar_func_select_a;
      ADDR_FUNC_B: next_rdata = crossbar_func_select_b;
      ADDR_IN_MODE: next_rdata = port_input_mode;
      ADDR_OUT_MODE: next_rdata = port_output_mode;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // Bit reads follow the same latch-or-pin choice
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_bit_rdata <= 1'b0;
    end else if (sfr_bit_rd) begin
      if (!bit_hit) begin
        sfr_bit_rdata <= 1'b0;
      end else if (sfr_rmw) begin
        sfr_bit_rdata <= port_data_latch[bit_idx];
      end else begin
        sfr_bit_rdata <= pin_level[bit_idx] & port_input_mode[bit_idx];
      end
    end
  end

  // Pin drive: crossbar function or latch, then driver mode
  always_comb begin
    next_out = '0;
    next_oe_n = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      logic val;
      logic od;
      val = port_data_latch[p];
      od = ~port_output_mode[p];
      if (pin_taken[p]) begin
        val = func_out[pin_func[p]];
        if (pin_func[p] == 3'(FUNC_TW_DATA) || pin_func[p] == 3'(FUNC_TW_CLK)) begin
          od = 1'b1;
        end
      end
      next_out[p] = val;
      if (!port_input_mode[p]) begin
        next_oe_n[p] = 1'b1;
      end else if (od) begin
        next_oe_n[p] = val;
      end else begin
        next_oe_n[p] = 1'b0;
      end
    end
    if (debug_data_oe) begin
      next_out[DEBUG_PIN] = debug_data_out;
      next_oe_n[DEBUG_PIN] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out <= RST_PORT_DATA;
    end else begin
      pin_out <= next_out;
    end
  end

  // Reset leaves every pin released
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_oe_n <= '1;
    end else begin
      pin_oe_n <= next_oe_n;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_analog <= ~RST_IN_MODE;
    end else begin
      pin_analog <= ~port_input_mode;
    end
  end

  // Peripheral inputs see the level of their assigned pin
  always_comb begin
    next_func_in = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_taken[p]) begin
        next_func_in[pin_func[p]] = pin_level[p] & port_input_mode[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      func_in <= '0;
    end else begin
      func_in <= next_func_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      debug_data_in <= 1'b1;
    end else begin
      debug_data_in <= pin_level[DEBUG_PIN];
    end
  end

  // Interrupt taps read pin levels only and never touch drive
  always_comb begin
    next_irq_zero = sel_pin(pin_level, irq_zero_pin_select);
    next_irq_zero = irq_zero_polarity ? next_irq_zero : ~next_irq_zero;
    if (!port_input_mode[irq_zero_pin_select]) begin
      next_irq_zero = 1'b0;
    end
    next_irq_one = sel_pin(pin_level, irq_one_pin_select);
    next_irq_one = irq_one_polarity ? ~next_irq_one : next_irq_one;
    if (!port_input_mode[irq_one_pin_select]) begin
      next_irq_one = 1'b0;
    end
  end

  // Edge of each level, one cycle ahead of the registered level
  assign next_rise_zero = next_irq_zero & ~external_irq_zero;
  assign next_rise_one = next_irq_one & ~external_irq_one;

  // Reset levels match the reset config on idle high pins, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      external_irq_zero <= RST_IRQ_CFG[IRQ0_POL_BIT];
    end else begin
      external_irq_zero <= next_irq_zero;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      external_irq_one <= ~RST_IRQ_CFG[IRQ1_POL_BIT];
    end else begin
      external_irq_one <= next_irq_one;
    end
  end

  // Assertion edges, one-cycle pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_zero_event <= 1'b0;
    end else begin
      irq_zero_event <= next_rise_zero;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_one_event <= 1'b0;
    end else begin
      irq_one_event <= next_rise_one;
    end
  end

  // Either edge wakes the device
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= next_rise_zero | next_rise_one;
    end
  end
endmodule
`default_nettype wire

// [bench/pzio_pins.sv]
// Board side of the port: pull-ups and an external driver per pin
`default_nettype none
module pzio_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // Device drive wins; a released pin takes the external driver if enabled, else floats to the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/pzio_chk.sv]
// Port zero checker: register reads and interrupt events
`default_nettype none
module pzio_chk import pzio_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_wval,
  input wire logic sfr_bit_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_bit_rdata,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_analog,
  input wire logic external_irq_zero,
  input wire logic external_irq_one,
  input wire logic irq_zero_event,
  input wire logic irq_one_event,
  input wire logic wake_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RMW_BYTE: assert property (
    sfr_wr && !sfr_bit_wr && sfr_addr == ADDR_PORT_DATA ##1 sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT_DATA
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("rmw byte read");
  AST_RMW_BIT: assert property (
    sfr_bit_wr && !sfr_wr && sfr_bit_addr[7:3] == 5'h10 ##1 sfr_bit_rd && sfr_rmw && $stable(sfr_bit_addr)
    |=> sfr_bit_rdata == $past(sfr_bit_wval, 2)) else $error("rmw bit read");
  AST_RD_HOLD: assert property (
    !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
  AST_UNMAPPED: assert property (
    sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00) else $error("unmapped read");
  AST_EVT_ZERO: assert property (
    irq_zero_event == (external_irq_zero && !$past(external_irq_zero))) else $error("event zero");
  AST_EVT_ONE: assert property (
    $rose(external_irq_one) |-> irq_one_event ##1 !irq_one_event) else $error("event one");
  AST_WAKE: assert property (
    wake_event == (irq_zero_event || irq_one_event)) else $error("wake");
  AST_ANALOG: assert property (
    (pin_analog & ~pin_oe_n) == 8'h00) else $error("analog driven");
endmodule
bind pzio_top pzio_chk u_chk (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_bit_addr,
  .sfr_bit_wr, .sfr_bit_wval, .sfr_bit_rd, .sfr_rdata, .sfr_bit_rdata, .pin_oe_n, .pin_analog,
  .external_irq_zero, .external_irq_one, .irq_zero_event, .irq_one_event, .wake_event);
`default_nettype wire

// [bench/pzio_top_tb.sv]
// Port zero testbench: registers, pin levels, crossbar, interrupts
`default_nettype none
module pzio_top_tb import pzio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA [8] = '{ADDR_PORT_DATA, ADDR_IRQ_CFG, ADDR_SKIP, ADDR_FUNC_A, ADDR_FUNC_B,
    ADDR_IN_MODE, ADDR_OUT_MODE, 8'h00};
  localparam logic [7:0] RV [8] = '{8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic clk = '0, srst = '1, sfr_wr = '0, sfr_rd = '0, sfr_rmw = '0, sfr_bit_wr = '0, sfr_bit_wval = '0;
  logic sfr_bit_rd = '0, dbg_oe = '0, dbg_out = '0, rd_q = '0, brd_q = '0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_bit_addr = '0, func_out = '0, ext_en = '0, ext_val = '0;
  logic [7:0] v = 8'h16;
  logic [7:0] sfr_rdata, pin_in, pin_out, pin_oe_n, pin_analog, func_in;
  logic sfr_bit_rdata, dbg_in, irq0, irq1, ev0, ev1, wake;
  logic [7:0] rq [$];
  logic bq [$];
  // Irq one starts active on its idle high pin, with no edge from reset
  int err_total = 0, n_compared = 0, ev0_exp = 0, ev1_exp = 0;
  always #4 clk = ~clk;
  pzio_top uut (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_bit_addr, .sfr_bit_wr,
    .sfr_bit_wval, .sfr_bit_rd, .sfr_rdata, .sfr_bit_rdata, .func_out, .func_in, .debug_data_oe(dbg_oe),
    .debug_data_out(dbg_out), .debug_data_in(dbg_in), .pin_in, .pin_out, .pin_oe_n, .pin_analog,
    .external_irq_zero(irq0), .external_irq_one(irq1), .irq_zero_event(ev0), .irq_one_event(ev1),
    .wake_event(wake));
  pzio_pins u_pins (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Kinds: 0 idle, 1 byte write, 2 byte read, 3 bit write, 4 bit read
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] d, input logic m);
    @(negedge clk);
    sfr_wr = k == 1;
    sfr_rd = k == 2;
    sfr_bit_wr = k == 3;
    sfr_bit_rd = k == 4;
    sfr_rmw = m;
    sfr_addr = a;
    sfr_bit_addr = a;
    sfr_wdata = d;
    sfr_bit_wval = d[0];
    if (k == 2) rq.push_back(d);
    if (k == 4) bq.push_back(d[0]);
  endtask
  task automatic idle(input int n);
    repeat (n) op(0, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic wev;
    for (int i = 0; i < 20 && (ev0_exp != 0 || ev1_exp != 0); i++) idle(1);
    if (ev0_exp != 0 || ev1_exp != 0) begin
      err_total++;
      $display("wrong value pending events expected 0 seen %0d", ev0_exp + ev1_exp);
      test_done();
    end
  endtask
  always @(posedge clk) begin
    rd_q <= sfr_rd;
    brd_q <= sfr_bit_rd;
  end
  always @(negedge clk) begin
    if (rd_q) chk(sfr_rdata, rq.pop_front(), "read data");
    if (brd_q) chk({7'h00, sfr_bit_rdata}, {7'h00, bq.pop_front()}, "bit data");
    if (ev0 === 1'b1) begin
      chk(8'(ev0_exp), 8'h01, "event zero");
      ev0_exp = 0;
    end
    if (ev1 === 1'b1) begin
      chk(8'(ev1_exp), 8'h01, "event one");
      ev1_exp = 0;
    end
  end
  initial begin
    #100000;
    err_total++;
    $display("wrong value run expected done seen timeout");
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 8; i++) op(2, RA[i], RV[i], 1'b1);
    op(2, ADDR_PORT_DATA, 8'hFF, 1'b0);
    chk({7'h00, irq1}, 8'h01, "irq one reset");
    // Park both interrupts on pin 7, kept high below
    op(1, ADDR_IRQ_CFG, 8'h77, 1'b0);
    repeat (4) begin
      v = lfsr(v);
      op(1, ADDR_PORT_DATA, v | 8'h80, 1'b0);
      op(2, ADDR_PORT_DATA, v | 8'h80, 1'b1);
    end
    idle(6);
    op(2, ADDR_PORT_DATA, v | 8'h80, 1'b0);
    op(1, ADDR_PORT_DATA, 8'hFF, 1'b0);
    ext_en = 8'h01;
    idle(6);
    op(2, ADDR_PORT_DATA, 8'hFE, 1'b0);
    op(2, ADDR_PORT_DATA, 8'hFF, 1'b1);
    op(4, BIT_BASE_PORT, 8'h00, 1'b0);
    op(4, BIT_BASE_PORT, 8'h01, 1'b1);
    op(3, 8'h83, 8'h00, 1'b0);
    op(4, 8'h83, 8'h00, 1'b1);
    idle(6);
    op(2, ADDR_PORT_DATA, 8'hF6, 1'b0);
    ev0_exp = 1;
    dbg_oe = 1'b1;
    wev();
    chk({7'h00, dbg_in}, 8'h00, "debug in");
    op(4, 8'h87, 8'h00, 1'b0);
    ev1_exp = 1;
    dbg_oe = 1'b0;
    wev();
    op(1, ADDR_PORT_DATA, 8'hFF, 1'b0);
    ev0_exp = 1;
    ext_en = 8'hFF;
    wev();
    for (int k = 0; k < 8; k++) begin
      op(1, ADDR_IRQ_CFG, {1'b0, 3'(k), 1'b1, 3'(k)}, 1'b0);
      idle(6);
      ev0_exp = 1;
      ev1_exp = 1;
      ext_val = 8'h01 << k;
      wev();
      ext_val = 8'h00;
      idle(6);
    end
    ev1_exp = 1;
    op(1, ADDR_IRQ_CFG, 8'h88, 1'b0);
    wev();
    chk({7'h00, irq1}, 8'h01, "irq one level");
    op(1, ADDR_IRQ_CFG, 8'h8A, 1'b0);
    op(1, ADDR_IN_MODE, 8'hFB, 1'b0);
    ext_val = 8'h04;
    idle(6);
    chk(pin_analog, 8'h04, "analog mode");
    chk({7'h00, irq0}, 8'h00, "analog irq");
    op(2, ADDR_PORT_DATA, 8'h00, 1'b0);
    ev0_exp = 1;
    op(1, ADDR_IN_MODE, 8'hFF, 1'b0);
    wev();
    ext_val = 8'h00;
    idle(6);
    ev0_exp = 1;
    ext_en = 8'h00;
    wev();
    op(1, ADDR_SKIP, 8'h03, 1'b0);
    op(1, ADDR_OUT_MODE, 8'hFF, 1'b0);
    op(1, ADDR_FUNC_A, 8'h03, 1'b0);
    idle(6);
    chk(pin_oe_n, 8'h00, "drive enables");
    chk(pin_out, 8'hF3, "drive values");
    ev0_exp = 1;
    func_out = 8'h03;
    wev();
    chk(pin_oe_n, 8'h0C, "open drain");
    chk(func_in, 8'h03, "function inputs");
    test_done();
  end
endmodule
`default_nettype wire
